// [shared/vrc_consts.vh]
// Constants for the voltage reference control block.
// Included by the design only; definitions only.
`ifndef VRC_CONSTS_VH
`define VRC_CONSTS_VH

`define VRC_ADDR_W 8
`define VRC_OFF_SELECT 8'h00
`define VRC_OFF_FORCE 8'h01
`define VRC_SELECT_RESET 8'h00
`define VRC_FORCE_RESET 8'h00
`define VRC_SELECT_MASK 8'h07
`define VRC_FORCE_MASK 8'h07
`define VRC_BIT_COMPARATOR_FORCE 0
`define VRC_BIT_CONVERTER_FORCE 1
`define VRC_BIT_MEMORY_FORCE 2
`define VRC_LEVEL_1024MV 3'h0
`define VRC_LEVEL_2048MV 3'h1
`define VRC_LEVEL_2500MV 3'h2
`define VRC_LEVEL_4096MV 3'h3
`define VRC_LEVEL_SUPPLY 3'h7
`define VRC_NUM_LEVELS 5

`endif

// [rtl/vrc_voltage_reference_control.v]
// Voltage reference control: select and force registers plus source enables.
// Assumes requests arrive from analog requesters outside the clock domain,
// and a single-cycle register port from a master on clk_sys_in.
`timescale 1ns/1ns
`include "vrc_consts.vh"

module vrc_voltage_reference_control (
	input wire clk_sys_in,
	input wire sys_rst_in,
	input wire clk_en_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [7:0] reg_rdata_out,
	input wire converter_request_in,
	input wire comparator_request_in,
	input wire memory_request_in,
	output reg converter_reference_on_out,
	output reg comparator_divider_reference_on_out,
	output reg memory_reference_on_out,
	output reg [`VRC_NUM_LEVELS-1:0] comparator_level_onehot_out,
	output reg comparator_level_reserved_out
);

	localparam SOURCES = 3;
	localparam SEL_W = 3;
	localparam [7:0] SELECT_RESET = `VRC_SELECT_RESET;
	localparam [7:0] FORCE_RESET = `VRC_FORCE_RESET;
	localparam [7:0] SELECT_MASK = `VRC_SELECT_MASK;
	localparam [7:0] FORCE_MASK = `VRC_FORCE_MASK;
	localparam [`VRC_NUM_LEVELS-1:0] ONEHOT_1024MV = 5'h01;
	localparam [`VRC_NUM_LEVELS-1:0] ONEHOT_2048MV = 5'h02;
	localparam [`VRC_NUM_LEVELS-1:0] ONEHOT_2500MV = 5'h04;
	localparam [`VRC_NUM_LEVELS-1:0] ONEHOT_4096MV = 5'h08;
	localparam [`VRC_NUM_LEVELS-1:0] ONEHOT_SUPPLY = 5'h10;
	localparam [`VRC_NUM_LEVELS-1:0] ONEHOT_NONE = 5'h00;

	// Upper bits are never stored, so they cannot read back
	reg [SEL_W-1:0] comparator_level_select;
	reg [SOURCES-1:0] reference_force_enables;
	reg [7:0] next_rdata;
	reg [`VRC_NUM_LEVELS-1:0] next_level;
	reg next_reserved;
	wire [SOURCES-1:0] req_raw;
	wire [SOURCES-1:0] next_on;
	wire select_hit;
	wire force_hit;
	wire select_write;
	wire force_write;
	wire read_take;
	wire [7:0] select_wdata;
	wire [7:0] force_wdata;
	genvar gi;

	// Request bits share the force bit positions, so one loop serves both
	assign req_raw[`VRC_BIT_COMPARATOR_FORCE] = comparator_request_in;
	assign req_raw[`VRC_BIT_CONVERTER_FORCE] = converter_request_in;
	assign req_raw[`VRC_BIT_MEMORY_FORCE] = memory_request_in;

	assign select_hit = (reg_addr_in == `VRC_OFF_SELECT);
	assign force_hit = (reg_addr_in == `VRC_OFF_FORCE);
	assign select_write = clk_en_in & reg_wr_in & select_hit;
	assign force_write = clk_en_in & reg_wr_in & force_hit;
	assign read_take = clk_en_in & reg_rd_in;
	assign select_wdata = reg_wdata_in & SELECT_MASK;
	assign force_wdata = reg_wdata_in & FORCE_MASK;

	always @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			comparator_level_select <= SELECT_RESET[SEL_W-1:0];
		end else if (select_write) begin
			comparator_level_select <= select_wdata[SEL_W-1:0];
		end
	end

	always @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			reference_force_enables <= FORCE_RESET[SOURCES-1:0];
		end else if (force_write) begin
			reference_force_enables <= force_wdata[SOURCES-1:0];
		end
	end

	// Per-source request filter and enable merge
	generate
		for (gi = 0; gi < SOURCES; gi = gi + 1) begin : g_src
			reg req_s1;
			reg req_s2;
			reg req_s3;
			reg req_stable;

			// Only stage two reads stage one, which may be metastable
			always @(posedge clk_sys_in) begin
				if (sys_rst_in) begin
					req_s1 <= 1'b0;
					req_s2 <= 1'b0;
					req_s3 <= 1'b0;
				end else if (clk_en_in) begin
					req_s1 <= req_raw[gi];
					req_s2 <= req_s1;
					req_s3 <= req_s2;
				end
			end

			// Stages two and three must agree, so a one-cycle glitch is ignored
			always @(posedge clk_sys_in) begin
				if (sys_rst_in) begin
					req_stable <= 1'b0;
				end else if (clk_en_in && (req_s2 == req_s3)) begin
					req_stable <= req_s3;
				end
			end

			assign next_on[gi] = req_stable | reference_force_enables[gi];
		end
	endgenerate

	always @* begin
		next_rdata = 8'h00;
		case (reg_addr_in)
			`VRC_OFF_SELECT: begin
				next_rdata = {5'h00, comparator_level_select};
			end
			`VRC_OFF_FORCE: begin
				next_rdata = {5'h00, reference_force_enables};
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	// Reserved codes light no level, so the comparator sees no reference
	always @* begin
		next_level = ONEHOT_NONE;
		next_reserved = 1'b0;
		case (comparator_level_select)
			`VRC_LEVEL_1024MV: begin
				next_level = ONEHOT_1024MV;
			end
			`VRC_LEVEL_2048MV: begin
				next_level = ONEHOT_2048MV;
			end
			`VRC_LEVEL_2500MV: begin
				next_level = ONEHOT_2500MV;
			end
			`VRC_LEVEL_4096MV: begin
				next_level = ONEHOT_4096MV;
			end
			`VRC_LEVEL_SUPPLY: begin
				next_level = ONEHOT_SUPPLY;
			end
			default: begin
				next_reserved = 1'b1;
			end
		endcase
	end

	// Read data hold until the next read; the master takes them the cycle after
	always @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (read_take) begin
			reg_rdata_out <= next_rdata;
		end
	end

	// Enables are flops, so the analog side never sees decode glitches
	always @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			comparator_divider_reference_on_out <= 1'b0;
		end else if (clk_en_in) begin
			comparator_divider_reference_on_out <= next_on[`VRC_BIT_COMPARATOR_FORCE];
		end
	end

	always @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			converter_reference_on_out <= 1'b0;
		end else if (clk_en_in) begin
			converter_reference_on_out <= next_on[`VRC_BIT_CONVERTER_FORCE];
		end
	end

	always @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			memory_reference_on_out <= 1'b0;
		end else if (clk_en_in) begin
			memory_reference_on_out <= next_on[`VRC_BIT_MEMORY_FORCE];
		end
	end

	// Reset value matches select code zero, so no reserved flash after reset
	always @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			comparator_level_onehot_out <= ONEHOT_1024MV;
		end else if (clk_en_in) begin
			comparator_level_onehot_out <= next_level;
		end
	end

	always @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			comparator_level_reserved_out <= 1'b0;
		end else if (clk_en_in) begin
			comparator_level_reserved_out <= next_reserved;
		end
	end

endmodule // vrc_voltage_reference_control

// [dv/vrc_requester.sv]
// Model of the converter, comparator and memory requesters.
// Assumes the bench commands each request level.
`timescale 1ns/1ns
module vrc_requester(input logic clk_in, input logic [2:0] want_in, output logic [2:0] req_out = 0);
	always @(posedge clk_in) req_out <= want_in;
endmodule // vrc_requester

// [dv/vrc_asserts.sv]
// Port checker for the reference control block.
// Sees only the block's ports; enable-low cycles are allowed for.
`timescale 1ns/1ns
module vrc_asserts(input logic clk_sys_in, sys_rst_in, clk_en_in, reg_wr_in, reg_rd_in,
	converter_request_in, converter_reference_on_out, memory_reference_on_out,
	comparator_level_reserved_out, input logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
	input logic [4:0] comparator_level_onehot_out);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	a_rst_vals: assert property ($fell(sys_rst_in) |-> comparator_level_onehot_out == 5'h01)
		else $error("reset");
	a_conv_req: assert property ((clk_en_in && converter_request_in) [*6]
		|-> converter_reference_on_out) else $error("request");
	a_read_clean: assert property (reg_rd_in |=> reg_rdata_out[7:3] == 5'h00)
		else $error("upper");
	a_read_unmapped: assert property (clk_en_in && reg_rd_in && reg_addr_in > 8'h01
		|=> !reg_rdata_out) else $error("unmapped");
	a_level_code: assert property (comparator_level_reserved_out ? !comparator_level_onehot_out
		: $onehot(comparator_level_onehot_out)) else $error("decode");
	a_sel_supply: assert property (clk_en_in && reg_wr_in && !reg_addr_in
		&& reg_wdata_in[2:0] == 3'h7 ##1 clk_en_in
		|=> comparator_level_onehot_out == 5'h10) else $error("supply");
	a_conv_force: assert property (clk_en_in && reg_wr_in && reg_addr_in == 8'h01
		&& reg_wdata_in[1] ##1 clk_en_in |=> converter_reference_on_out) else $error("converter");
	a_mem_force: assert property (clk_en_in && reg_wr_in && reg_addr_in == 8'h01
		&& reg_wdata_in[2] ##1 clk_en_in |=> memory_reference_on_out) else $error("memory");
endmodule // vrc_asserts
bind vrc_voltage_reference_control vrc_asserts vrc_asserts_inst(.*);

// [dv/vrc_voltage_reference_control_tb.sv]
// Bench for the reference control block.
// Assumes the requester model drives the three requests.
`timescale 1ns/1ns
module vrc_voltage_reference_control_tb;
	logic clk = 0, rst = 1, wr = 0, rd = 0, en = 1, resv;
	logic [7:0] addr = 0, wd = 0, q;
	logic [2:0] want = 0, req, on;
	logic [4:0] hot;
	int errors = 0, total_checks = 0;
	always #5 clk = ~clk;
	vrc_requester vrc_requester_inst(.clk_in(clk), .want_in(want), .req_out(req));
	vrc_voltage_reference_control vrc_voltage_reference_control_inst(.clk_sys_in(clk),
		.sys_rst_in(rst), .clk_en_in(en), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(q), .converter_request_in(req[1]),
		.comparator_request_in(req[0]), .memory_request_in(req[2]),
		.converter_reference_on_out(on[1]), .comparator_divider_reference_on_out(on[0]),
		.memory_reference_on_out(on[2]), .comparator_level_onehot_out(hot),
		.comparator_level_reserved_out(resv));
	task chk(input logic [7:0] g, e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %0t %h %h", $time, g, e);
		end
	endtask
	task wreg(input logic [7:0] a, d);
		@(posedge clk) {addr, wd, wr} <= {a, d, 1'b1};
		@(posedge clk) wr <= 0;
	endtask
	task rchk(input logic [7:0] a, e);
		@(posedge clk) {addr, rd} <= {a, 1'b1};
		@(posedge clk) rd <= 0;
		#1 chk(q, e);
	endtask
	task t_levels;
		for (int c = 0; c < 8; c++) begin
			wreg(8'h00, 8'hF8 | c[7:0]);
			rchk(8'h00, c[7:0]);
			chk({resv, 2'h0, hot}, c > 3 && c < 7 ? 8'h80 : c == 7 ? 8'h10 : 8'h01 << c);
		end
	endtask
	task t_force;
		for (int b = 0; b < 3; b++) begin
			wreg(8'h01, 8'h01 << b);
			rchk(8'h01, 8'h01 << b);
			chk(on, 3'h1 << b);
		end
		wreg(8'h01, 8'h00);
	endtask
	task t_request;
		want <= 3'h5;
		repeat (8) @(posedge clk);
		#1 chk(on, 3'h5);
		want <= 3'h0;
		repeat (8) @(posedge clk);
		#1 chk(on, 3'h0);
	endtask
	task t_freeze;
		@(posedge clk) en <= 0;
		wreg(8'h01, 8'h07);
		en <= 1;
		rchk(8'h01, 8'h00);
		chk(on, 8'h00);
	endtask
	task t_reset;
		wreg(8'h00, 8'h03);
		wreg(8'h01, 8'h07);
		@(posedge clk) rst <= 1;
		@(posedge clk) rst <= 0;
		rchk(8'h00, 8'h00);
		rchk(8'h01, 8'h00);
		chk(on, 8'h00);
		chk(hot, 8'h01);
	endtask
	task end_sim;
		$display("errors %0d total_checks %0d", errors, total_checks);
		if (errors == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 0;
		rchk(8'h01, 8'h00);
		rchk(8'h07, 8'h00);
		t_levels;
		t_force;
		t_request;
		t_freeze;
		t_reset;
		end_sim;
	end
	initial begin
		#20000 errors++;
		end_sim;
	end
endmodule // vrc_voltage_reference_control_tb
